/* File: inc/selink_consts.svh */
// constants shared by both ends of the secure element serial link
`ifndef SELINK_CONSTS_SVH
`define SELINK_CONSTS_SVH
`define SELINK_BYTE_BITS 8
`define SELINK_FIFO_DEPTH 32
`define SELINK_CLK_DIV 16
`define SELINK_SYNC_RESET 2'h3
`endif

/* File: inc/selink_pkg.sv */
// types for the host master end of the secure element serial link
package selink_pkg;
  typedef enum logic [1:0] {
    SELINK_IDLE = 2'h0,
    SELINK_SEL = 2'h1,
    SELINK_SHIFT = 2'h3,
    SELINK_DONE = 2'h2
  } selink_mst_state_type;
endpackage

/* File: inc/selink_if.sv */
// link wires between the host master and the secure element slave
`timescale 1ns/1ps
interface selink_if;
  // serial clock and data
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // dedicated request line (five-signal variant)
  logic req;
  // open-drain select line
  logic master_select_drive;
  logic slave_select_drive;
  logic select_n_line;
  // wired-and with pull-up; undriven miso reads high
  assign select_n_line = ~(master_select_drive | slave_select_drive);
  assign miso = miso_oe ? miso_o : 1'b1;
  modport master (
    output sclk,
    output mosi,
    input miso,
    input req,
    output master_select_drive,
    input select_n_line
  );
  modport slave (
    input sclk,
    input mosi,
    output miso_o,
    output miso_oe,
    output req,
    output slave_select_drive,
    input select_n_line
  );
endinterface

/* File: design/selink_fifo.sv */
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module selink_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // honest full and empty from pointer compare
  assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data = mem[rd_ff[AW-1:0]];
  // storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW+1)'(push);
      rd_ff <= rd_ff + (AW+1)'(pop);
    end
  end
endmodule

/* File: design/selink_slave.sv */
// secure element end of the serial link, mode 0 slave
// Summary of operation
// RULE1: request line high means asserted
// RULE2: slave raises request to get transfer
// RULE3: select low is asserted, high idle
// RULE4: select driven only as open drain
// RULE5: four-signal slave requests by pulling select
// RULE6: select low when any drive active
// RULE7: master select drive high pulls low
// RULE8: slave select drive high pulls low
// RULE9: select sense high idle, low asserted
// RULE10: master keeps serial clock low idle
// RULE11: sample data on rising clock edges
// RULE12: same byte count both directions
// RULE13: master selects then clocks configured bytes
// RULE14: slave drives miso, master drives mosi
// RULE15: slave may start without master command
// RULE16: miso undriven while select idle
`timescale 1ns/1ps
`include "selink_consts.svh"
module selink_slave #(
  parameter int FIFO_DEPTH = `SELINK_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  selink_if.slave lnk,
  // variant: 1 uses select line for requests
  input wire logic four_wire,
  // transmit bytes from user
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // received bytes to user
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // user asks for service
  input wire logic service_req,
  output logic busy
);
  logic [1:0] sclk_sync_ff;
  logic [1:0] sel_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic sclk_d_ff;
  logic [7:0] sh_in_ff;
  logic [7:0] sh_out_ff;
  logic [2:0] bit_ff;
  logic rx_push_ff;
  logic [7:0] rx_byte_ff;
  logic miso_ff;
  logic sent_ff;
  logic miso_oe_ff;
  logic req_ff;
  logic sdrive_ff;
  logic busy_ff;
  logic fifo_tx_valid;
  logic [7:0] fifo_tx_data;
  logic rx_in_ready;
  // serial clock passes two flops, reset to its idle low level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_ff <= 2'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], lnk.sclk};
    end
  end
  // select passes two flops, reset to idle high so no false select follows reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_ff <= `SELINK_SYNC_RESET;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], lnk.select_n_line};
    end
  end
  // data in passes the same two flops as the clock, so each bit lines up with its edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mosi_sync_ff <= 2'h0;
    end else begin
      mosi_sync_ff <= {mosi_sync_ff[0], lnk.mosi};
    end
  end
  // delayed clock copy for edge detection, idle low so reset gives no false edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_sync_ff[1];
    end
  end
  // select and clock edges, decoded from the synchronised copies
  wire selected = ~sel_sync_ff[1]; // low is asserted [RULE3] [RULE9]
  wire rise = sclk_sync_ff[1] & ~sclk_d_ff; // [RULE11]
  wire fall = ~sclk_sync_ff[1] & sclk_d_ff;
  // eighth rise ends a byte, the fall after it starts the next one
  wire byte_end = rise & (bit_ff == 3'h7);
  wire byte_start = fall & (bit_ff == 3'h0);
  // the fifo head is popped only once all its bits have gone out
  wire have_tx = fifo_tx_valid;
  wire tx_pop = byte_end & selected & sent_ff;
  // next byte out: fifo word or filler, one per received byte [RULE12]
  wire [7:0] nxt_load = have_tx ? fifo_tx_data : 8'h00;
  // received byte assembly; a full rx fifo drops the byte
  wire rx_take = byte_end & selected & rx_in_ready;
  wire [7:0] rx_word = {sh_in_ff[6:0], mosi_sync_ff[1]};
  // outgoing bytes buffered toward the link
  selink_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(fifo_tx_valid),
    .out_data(fifo_tx_data),
    .out_ready(tx_pop)
  );
  // incoming bytes buffered toward the user
  selink_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(rx_push_ff),
    .in_data(rx_byte_ff),
    .in_ready(rx_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );
  // received byte handed to the rx fifo one cycle after its last bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_push_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_push_ff <= rx_take;
      if (byte_end & selected) begin
        rx_byte_ff <= rx_word;
      end
    end
  end
  // input shifter: sample mosi on each rise [RULE11]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_in_ff <= 8'h00;
    end else if (selected & rise) begin
      sh_in_ff <= rx_word;
    end
  end
  // bit counter: cleared while idle, one step per rise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_ff <= 3'h0;
    end else if (!selected) begin
      bit_ff <= 3'h0;
    end else if (rise) begin
      bit_ff <= bit_ff + 3'h1;
    end
  end
  // output shifter: load while idle and at each byte start, shift on rise [RULE12] [RULE14]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_out_ff <= 8'h00;
      sent_ff <= 1'b0;
    end else if (!selected || byte_start) begin
      sh_out_ff <= nxt_load;
      sent_ff <= have_tx;
    end else if (rise) begin
      sh_out_ff <= {sh_out_ff[6:0], 1'b0};
    end
  end
  // miso changes only on falls and while deselected, so it stands still over every rise [RULE11] [RULE14]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_ff <= 1'b0;
    end else if (!selected || byte_start) begin
      miso_ff <= nxt_load[7];
    end else if (fall) begin
      miso_ff <= sh_out_ff[7];
    end
  end
  // request decode: pending data or user ask starts service [RULE15]
  wire ask = fifo_tx_valid | service_req;
  wire want = ask & ~selected;
  // pull ends at the first rise, and is never raised when the master selected first
  wire pull_done = selected & rise;
  wire master_first = selected & ~sdrive_ff;
  wire nxt_sdrive = four_wire & ask & ~pull_done & ~master_first;
  // dedicated request line, high only while asking [RULE1] [RULE2]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff <= 1'b0;
    end else begin
      req_ff <= want & ~four_wire;
    end
  end
  // pull select low to ask, release once clocking starts [RULE5] [RULE8]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdrive_ff <= 1'b0;
    end else begin
      sdrive_ff <= nxt_sdrive;
    end
  end
  // slave output hi-z while not selected [RULE16]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= selected;
    end
  end
  // busy mirrors the synchronised select
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= selected;
    end
  end
  assign lnk.req = req_ff;
  assign lnk.slave_select_drive = sdrive_ff; // open drain pull only [RULE4] [RULE6]
  assign lnk.miso_o = miso_ff;
  assign lnk.miso_oe = miso_oe_ff;
  assign busy = busy_ff;
endmodule

/* File: design/selink_master.sv */
// host end of the serial link, mode 0 master
`timescale 1ns/1ps
`include "selink_consts.svh"
module selink_master #(
  parameter int DIV = `SELINK_CLK_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  selink_if.master lnk,
  // variant and access length in bytes
  input wire logic four_wire,
  input wire logic [7:0] access_len,
  // access start and data
  input wire logic start,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic rx_valid,
  output logic [7:0] rx_data,
  // service request seen, and access running
  output logic service_pending,
  output logic busy
);
  selink_pkg::selink_mst_state_type st_ff;
  logic [7:0] div_ff;
  logic sclk_ff;
  logic mosi_ff;
  logic mdrive_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [7:0] left_ff;
  logic take_ff;
  logic rxv_ff;
  logic [7:0] rxd_ff;
  logic [1:0] miso_sync_ff;
  logic [1:0] req_sync_ff;
  logic [1:0] sel_sync_ff;
  logic [1:0] mdrv_dly_ff;
  logic pend_ff;
  logic busy_ff;
  wire tick = div_ff == 8'(DIV/2 - 1);
  wire last_bit = bit_ff == 3'h7;
  // own drive still shows in the select sync flops for two cycles after release
  wire own_pull = mdrive_ff | (|mdrv_dly_ff);
  // external inputs pass two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      miso_sync_ff <= 2'h0;
      req_sync_ff <= 2'h0;
      sel_sync_ff <= `SELINK_SYNC_RESET;
      pend_ff <= 1'b0;
      busy_ff <= 1'b0;
      mdrv_dly_ff <= 2'h0;
    end else begin
      miso_sync_ff <= {miso_sync_ff[0], lnk.miso};
      req_sync_ff <= {req_sync_ff[0], lnk.req};
      sel_sync_ff <= {sel_sync_ff[0], lnk.select_n_line};
      // select low while master not pulling means slave asks [RULE5] [RULE9]
      pend_ff <= four_wire ? (~sel_sync_ff[1] & ~own_pull) : req_sync_ff[1]; // [RULE2]
      mdrv_dly_ff <= {mdrv_dly_ff[0], mdrive_ff};
      busy_ff <= st_ff != selink_pkg::SELINK_IDLE;
    end
  end
  // access sequencer: select, clock len bytes, release [RULE13]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= selink_pkg::SELINK_IDLE;
      div_ff <= 8'h00;
      sclk_ff <= 1'b0;
      mosi_ff <= 1'b0;
      mdrive_ff <= 1'b0;
      sh_ff <= 8'h00;
      bit_ff <= 3'h0;
      left_ff <= 8'h00;
      take_ff <= 1'b0;
      rxv_ff <= 1'b0;
      rxd_ff <= 8'h00;
    end else begin
      take_ff <= 1'b0;
      rxv_ff <= 1'b0;
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
      case (st_ff)
        selink_pkg::SELINK_IDLE: begin
          sclk_ff <= 1'b0; // clock idles low [RULE10]
          if (start && access_len != 8'h00) begin
            mdrive_ff <= 1'b1; // high drive pulls select low [RULE7]
            left_ff <= access_len;
            sh_ff <= tx_data;
            mosi_ff <= tx_data[7];
            take_ff <= 1'b1;
            bit_ff <= 3'h0;
            st_ff <= selink_pkg::SELINK_SEL;
          end
        end
        selink_pkg::SELINK_SEL: begin
          if (tick) begin
            st_ff <= selink_pkg::SELINK_SHIFT;
          end
        end
        selink_pkg::SELINK_SHIFT: begin
          if (tick) begin
            sclk_ff <= ~sclk_ff;
            if (!sclk_ff) begin
              sh_ff <= {sh_ff[6:0], miso_sync_ff[1]}; // sample on rise [RULE11]
            end else begin
              bit_ff <= bit_ff + 3'h1;
              if (last_bit) begin
                rxv_ff <= 1'b1;
                rxd_ff <= sh_ff;
                left_ff <= left_ff - 8'h01; // equal count both ways [RULE12]
                if (left_ff == 8'h01) begin
                  st_ff <= selink_pkg::SELINK_DONE;
                end else begin
                  sh_ff <= tx_data;
                  mosi_ff <= tx_data[7];
                  take_ff <= 1'b1;
                end
              end else begin
                mosi_ff <= sh_ff[7]; // master drives mosi [RULE14]
              end
            end
          end
        end
        selink_pkg::SELINK_DONE: begin
          if (tick) begin
            mdrive_ff <= 1'b0;
            st_ff <= selink_pkg::SELINK_IDLE;
          end
        end
        default: begin
          st_ff <= selink_pkg::SELINK_IDLE;
        end
      endcase
    end
  end
  assign lnk.sclk = sclk_ff;
  assign lnk.mosi = mosi_ff;
  assign lnk.master_select_drive = mdrive_ff; // open drain pull only [RULE4] [RULE6]
  assign tx_take = take_ff;
  assign rx_valid = rxv_ff;
  assign rx_data = rxd_ff;
  assign service_pending = pend_ff;
  assign busy = busy_ff;
endmodule

/* File: sim/selink_checker.sv */
// link assertions for the host master and secure element slave pair
`timescale 1ns/1ps
module selink_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link wires
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic req,
  input wire logic master_select_drive,
  input wire logic slave_select_drive,
  input wire logic select_n_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // select line levels and request exclusivity
  a_sel_wired_and: assert property (
    select_n_line == !(master_select_drive || slave_select_drive))
    else $error("select line disagrees with drives");
  a_one_request: assert property (!(req && slave_select_drive))
    else $error("both request paths active");
  a_req_drop_sel: assert property (master_select_drive [*8] |-> !req)
    else $error("request line held while selected");
  a_slave_pull_drop: assert property (
    $rose(sclk) |-> ##[0:6] !slave_select_drive)
    else $error("slave select pull not dropped");
  // serial clock idle level, timing and select
  a_sclk_idle_low: assert property (!master_select_drive |-> !sclk)
    else $error("serial clock high while idle");
  a_clk_needs_sel: assert property ($rose(sclk) |-> !select_n_line)
    else $error("serial clock rose without select");
  a_sclk_half_len: assert property (
    $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  // data held over the sampling phase
  a_data_hold_high: assert property (
    sclk && $past(sclk) |-> $stable(mosi) && $stable(miso_o))
    else $error("data changed while clock high");
  // slave output enable follows select
  a_miso_released: assert property (select_n_line [*6] |-> !miso_oe)
    else $error("slave output driven while idle");
  a_miso_driven: assert property (sclk |-> miso_oe)
    else $error("slave output undriven during transfer");
endmodule

/* File: sim/tb.sv */
// self-checking bench joining host master and secure element slave
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic four_wire = 1'b0;
  logic s_tx_valid = 1'b0;
  logic s_rx_ready = 1'b1;
  logic service_req = 1'b0;
  logic m_start = 1'b0;
  logic [7:0] s_tx_data = 8'h00;
  logic [7:0] access_len = 8'h01;
  logic [7:0] m_tx_data = 8'h00;
  logic [7:0] s_rx_data, m_rx_data, mo_sh, mi_sh;
  logic s_tx_ready, s_rx_valid, s_busy, m_tx_take, m_rx_valid, service_pending, m_busy;
  logic [7:0] m_got[$];
  logic [7:0] s_got[$];
  int bad_count = 0;
  int checked = 0;
  // clock
  always #5 sys_clk = ~sys_clk;
  selink_if lnk();
  // divider 16 gives a 160 ns serial clock
  selink_master #(.DIV(16)) u_selink_master (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk),
    .four_wire(four_wire), .access_len(access_len), .start(m_start), .tx_data(m_tx_data),
    .tx_take(m_tx_take), .rx_valid(m_rx_valid), .rx_data(m_rx_data),
    .service_pending(service_pending), .busy(m_busy));
  selink_slave u_selink_slave (.sys_clk(sys_clk), .rst_b(rst_b), .lnk(lnk),
    .four_wire(four_wire), .tx_valid(s_tx_valid), .tx_data(s_tx_data), .tx_ready(s_tx_ready),
    .rx_valid(s_rx_valid), .rx_data(s_rx_data), .rx_ready(s_rx_ready),
    .service_req(service_req), .busy(s_busy));
  selink_checker u_selink_checker (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(lnk.sclk),
    .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe), .req(lnk.req),
    .master_select_drive(lnk.master_select_drive),
    .slave_select_drive(lnk.slave_select_drive), .select_n_line(lnk.select_n_line));
  // collect bytes; next master byte is previous plus 8'h11
  always @(posedge sys_clk) begin
    if (m_rx_valid === 1'b1) m_got.push_back(m_rx_data);
    if (s_rx_valid === 1'b1) s_got.push_back(s_rx_data);
    if (m_tx_take === 1'b1) m_tx_data <= m_tx_data + 8'h11;
  end
  // shift in the wire bits at the sampling edge, msb first
  always @(posedge lnk.sclk) begin
    mo_sh <= {mo_sh[6:0], lnk.mosi};
    mi_sh <= {mi_sh[6:0], lnk.miso};
  end
  task automatic push(input logic [7:0] b);
    s_tx_valid <= 1'b1;
    s_tx_data <= b;
    @(posedge sys_clk);
    while (s_tx_ready !== 1'b1) @(posedge sys_clk);
    s_tx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_pending;
    int n;
    n = 0;
    while (service_pending !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  // one access of len bytes, master sending first, first+8'h11, ...
  task automatic access(input logic [7:0] len, input logic [7:0] first);
    int n;
    n = 0;
    m_got.delete();
    s_got.delete();
    m_tx_data <= first;
    access_len <= len;
    m_start <= 1'b1;
    while (m_busy !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    m_start <= 1'b0;
    while (m_busy !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (8) @(posedge sys_clk);
    `CHK("master rx count", len, 8'(m_got.size()))
    `CHK("slave rx count", len, 8'(s_got.size()))
    `CHK("mosi bits", first + 8'(len - 1) * 8'h11, mo_sh)
    `CHK("select idle", 1'b1, lnk.select_n_line)
    `CHK("miso released", 1'b1, lnk.miso)
  endtask
  task automatic t_idle;
    `CHK("sclk idle", 1'b0, lnk.sclk)
    `CHK("select idle", 1'b1, lnk.select_n_line)
    `CHK("req idle", 1'b0, lnk.req)
    `CHK("slave busy idle", 1'b0, s_busy)
  endtask
  task automatic t_master_start;
    access(8'h01, 8'hA5);
    `CHK("slave rx", 8'hA5, s_got[0])
    `CHK("filler", 8'h00, m_got[0])
  endtask
  task automatic t_req_five;
    push(8'h3C);
    push(8'hE1);
    wait_pending();
    `CHK("req line", 1'b1, lnk.req)
    `CHK("pending", 1'b1, service_pending)
    `CHK("select kept", 1'b1, lnk.select_n_line)
    access(8'h02, 8'h5A);
    `CHK("master rx 0", 8'h3C, m_got[0])
    `CHK("master rx 1", 8'hE1, m_got[1])
    `CHK("slave rx 1", 8'h6B, s_got[1])
    `CHK("miso bits", 8'hE1, mi_sh)
    `CHK("req dropped", 1'b0, lnk.req)
  endtask
  task automatic t_req_four;
    four_wire <= 1'b1;
    service_req <= 1'b1;
    push(8'h77);
    wait_pending();
    `CHK("slave busy", 1'b1, s_busy)
    `CHK("slave pull", 1'b1, lnk.slave_select_drive)
    `CHK("master pull", 1'b0, lnk.master_select_drive)
    `CHK("select low", 1'b0, lnk.select_n_line)
    `CHK("pending", 1'b1, service_pending)
    `CHK("no req line", 1'b0, lnk.req)
    service_req <= 1'b0;
    access(8'h02, 8'h10);
    `CHK("master rx 0", 8'h77, m_got[0])
    `CHK("slave rx 0", 8'h10, s_got[0])
    `CHK("slave rx 1", 8'h21, s_got[1])
    `CHK("filler", 8'h00, m_got[1])
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_idle();
    t_master_start();
    t_req_five();
    t_req_four();
    stop_test();
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end
endmodule
